//--- design/fref_selector.sv
// frequency reference selector: multi-step, source decode, superposition, parameters
`timescale 1ns/10ps
module fref_selector
   import fref_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic input_terminal_1,
   input wire logic input_terminal_2,
   input wire logic input_terminal_3,
   input wire fref_src_t src,
   input wire logic param_wr_en,
   input wire logic [15:0] param_addr,
   input wire logic [15:0] param_wr_data,
   input wire logic [15:0] param_rd_addr,
   output logic [15:0] param_rd_data,
   output logic param_wr_err,
   input wire logic [2:0] plc_stage_index,
   output logic [15:0] plc_stage_time,
   output logic [15:0] plc_accel_time,
   output logic [15:0] plc_decel_time,
   output fref_plc_cfg_t plc_cfg,
   output logic [FREF_W-1:0] multistep_ref,
   output logic [FREF_W-1:0] main_ref,
   output logic [FREF_W-1:0] aux_ref,
   output logic [FREF_W-1:0] target_freq
);

   // ======================================================================
   // parameter store
   logic [15:0] main_sel_reg, main_sel_next;
   logic [15:0] aux_sel_reg, aux_sel_next;
   logic [15:0] sup_sel_reg, sup_sel_next;
   logic [15:0] step0_sel_reg, step0_sel_next;
   logic [15:0] plc_cfg_reg, plc_cfg_next;
   logic [15:0] in_func_reg [FREF_NUM_TERM];
   logic [15:0] in_func_next [FREF_NUM_TERM];
   logic [15:0] step_val_reg [FREF_NUM_STEP];
   logic [15:0] step_val_next [FREF_NUM_STEP];
   logic [15:0] stage_reg [FREF_NUM_STAGE_WORD];
   logic [15:0] stage_next [FREF_NUM_STAGE_WORD];
   logic [15:0] ramp_reg [FREF_NUM_RAMP_WORD];
   logic [15:0] ramp_next [FREF_NUM_RAMP_WORD];
   logic [15:0] rd_data_reg, rd_data_next;
   logic wr_err_reg, wr_err_next;
   logic [15:0] stage_off, ramp_off, func_off, step_off;

   // writes; an out-of-range superposition code is refused whole
   always_comb begin
      main_sel_next = main_sel_reg;
      aux_sel_next = aux_sel_reg;
      sup_sel_next = sup_sel_reg;
      step0_sel_next = step0_sel_reg;
      plc_cfg_next = plc_cfg_reg;
      in_func_next = in_func_reg;
      step_val_next = step_val_reg;
      stage_next = stage_reg;
      ramp_next = ramp_reg;
      wr_err_next = 1'b0;
      stage_off = param_addr - FREF_ADDR_STAGE_FIRST;
      ramp_off = param_addr - FREF_ADDR_RAMP_FIRST;
      func_off = param_addr - FREF_ADDR_IN_FUNC0;
      step_off = param_addr - FREF_ADDR_STEP0_SEL;
      if (param_wr_en) begin
         if (param_addr == FREF_ADDR_MAIN_SEL) begin
            main_sel_next = param_wr_data;
         end else if (param_addr == FREF_ADDR_AUX_SEL) begin
            aux_sel_next = param_wr_data;
         end else if (param_addr == FREF_ADDR_SUP_SEL) begin
            // ones digit above 4 or tens above 3 is not a legal code either
            if (param_wr_data > FREF_SUP_MAX || param_wr_data[3:0] > FREF_MODE_SW_YC) begin
               wr_err_next = 1'b1;
            end else begin
               sup_sel_next = param_wr_data;
            end
         end else if (param_addr == FREF_ADDR_STEP0_SEL) begin
            step0_sel_next = param_wr_data;
         end else if (param_addr >= FREF_ADDR_STEP1 && param_addr <= FREF_ADDR_STEP7) begin
            step_val_next[step_off[2:0]] = param_wr_data;
         end else if (param_addr >= FREF_ADDR_IN_FUNC0 && param_addr <= FREF_ADDR_IN_FUNC2) begin
            in_func_next[func_off[1:0]] = param_wr_data;
         end else if (param_addr == FREF_ADDR_PLC_CFG) begin
            plc_cfg_next = param_wr_data;
         end else if (param_addr >= FREF_ADDR_STAGE_FIRST &&
                      param_addr <= FREF_ADDR_STAGE_LAST) begin
            stage_next[stage_off[3:0]] = param_wr_data;
         end else if (param_addr >= FREF_ADDR_RAMP_FIRST &&
                      param_addr <= FREF_ADDR_RAMP_LAST) begin
            ramp_next[ramp_off[2:0]] = param_wr_data;
         end else begin
            wr_err_next = 1'b1;
         end
      end
   end

   // readback; unmapped addresses read zero
   always_comb begin
      logic [15:0] roff;
      roff = param_rd_addr - FREF_ADDR_STAGE_FIRST;
      rd_data_next = FREF_RST_WORD;
      if (param_rd_addr == FREF_ADDR_MAIN_SEL) begin
         rd_data_next = main_sel_reg;
      end else if (param_rd_addr == FREF_ADDR_AUX_SEL) begin
         rd_data_next = aux_sel_reg;
      end else if (param_rd_addr == FREF_ADDR_SUP_SEL) begin
         rd_data_next = sup_sel_reg;
      end else if (param_rd_addr == FREF_ADDR_STEP0_SEL) begin
         rd_data_next = step0_sel_reg;
      end else if (param_rd_addr >= FREF_ADDR_STEP1 && param_rd_addr <= FREF_ADDR_STEP7) begin
         roff = param_rd_addr - FREF_ADDR_STEP0_SEL;
         rd_data_next = step_val_reg[roff[2:0]];
      end else if (param_rd_addr >= FREF_ADDR_IN_FUNC0 &&
                   param_rd_addr <= FREF_ADDR_IN_FUNC2) begin
         roff = param_rd_addr - FREF_ADDR_IN_FUNC0;
         rd_data_next = in_func_reg[roff[1:0]];
      end else if (param_rd_addr == FREF_ADDR_PLC_CFG) begin
         rd_data_next = plc_cfg_reg;
      end else if (param_rd_addr >= FREF_ADDR_STAGE_FIRST &&
                   param_rd_addr <= FREF_ADDR_STAGE_LAST) begin
         rd_data_next = stage_reg[roff[3:0]];
      end else if (param_rd_addr >= FREF_ADDR_RAMP_FIRST &&
                   param_rd_addr <= FREF_ADDR_RAMP_LAST) begin
         roff = param_rd_addr - FREF_ADDR_RAMP_FIRST;
         rd_data_next = ramp_reg[roff[2:0]];
      end
   end

   // ======================================================================
   // terminal decode, one slice per terminal
   logic [FREF_NUM_TERM-1:0] term_in;
   logic [2:0] term_ms [FREF_NUM_TERM];
   logic [FREF_NUM_TERM-1:0] term_sw;
   logic [2:0] ms_idx;
   logic sw_on;

   assign term_in = {input_terminal_3, input_terminal_2, input_terminal_1};

   genvar gi;
   generate
      for (gi = 0; gi < FREF_NUM_TERM; gi++) begin : g_term
         // a terminal may carry any one function; bit k lights only for code 21+k
         assign term_ms[gi] = {3{term_in[gi]}} &
                              {in_func_reg[gi] == FREF_FUNC_MS3,
                               in_func_reg[gi] == FREF_FUNC_MS2,
                               in_func_reg[gi] == FREF_FUNC_MS1};
         assign term_sw[gi] = term_in[gi] && in_func_reg[gi] >= FREF_FUNC_SW_LO &&
                              in_func_reg[gi] <= FREF_FUNC_SW_HI;
      end
   endgenerate

   // input 1 is the lsb; taken straight from the pins so the result lands next edge
   always_comb begin
      ms_idx = 3'h0;
      for (int t = 0; t < FREF_NUM_TERM; t++) begin
         ms_idx = ms_idx | term_ms[t];
      end
      sw_on = |term_sw;
   end

   // ======================================================================
   // source selection
   logic [FREF_W-1:0] step0_val, ms_val, main_val, aux_val, comb_val, target_val;

   // step 0 cannot point at multi-step itself, so that loop is fed zero
   fref_src_mux u_step0 (
      .sel(step0_sel_reg[3:0]),
      .src(src),
      .multi_ref('0),
      .value(step0_val)
   );

   assign ms_val = (ms_idx == 3'h0) ? step0_val : step_val_reg[ms_idx];

   fref_src_mux u_main (
      .sel(main_sel_reg[3:0]),
      .src(src),
      .multi_ref(ms_val),
      .value(main_val)
   );

   // same decoder as main, so aux alone behaves identically
   fref_src_mux u_aux (
      .sel(aux_sel_reg[3:0]),
      .src(src),
      .multi_ref(ms_val),
      .value(aux_val)
   );

   // ======================================================================
   // superposition; signed with saturation so a sum never wraps negative
   always_comb begin
      logic signed [FREF_W:0] wide;
      logic signed [FREF_W-1:0] m, a;
      m = signed'(main_val);
      a = signed'(aux_val);
      wide = '0;
      unique case (sup_sel_reg[7:4])
         // widen both operands first so the carry is kept for saturation
         FREF_OP_SUM: wide = (FREF_W+1)'(m) + (FREF_W+1)'(a);
         FREF_OP_DIFF: wide = (FREF_W+1)'(m) - (FREF_W+1)'(a);
         FREF_OP_MAX: wide = (m > a) ? (FREF_W+1)'(m) : (FREF_W+1)'(a);
         default: wide = (m < a) ? (FREF_W+1)'(m) : (FREF_W+1)'(a);
      endcase
      if (wide > $signed({2'b00, {(FREF_W-1){1'b1}}})) begin
         comb_val = {1'b0, {(FREF_W-1){1'b1}}};
      end else if (wide < $signed({2'b11, {(FREF_W-1){1'b0}}})) begin
         comb_val = {1'b1, {(FREF_W-1){1'b0}}};
      end else begin
         comb_val = wide[FREF_W-1:0];
      end
      unique case (sup_sel_reg[3:0])
         FREF_MODE_MAIN: target_val = main_val;
         FREF_MODE_COMB: target_val = comb_val;
         FREF_MODE_SW_XY: target_val = sw_on ? aux_val : main_val;
         FREF_MODE_SW_XC: target_val = sw_on ? comb_val : main_val;
         default: target_val = sw_on ? comb_val : aux_val;
      endcase
   end

   // ======================================================================
   // plc stage lookup: even word is run time, odd word picks an accel/decel pair
   logic [15:0] stime_next, accel_next, decel_next;
   logic [15:0] stime_reg, accel_reg, decel_reg, ramp_pick_w;
   logic [FREF_W-1:0] ms_reg, main_reg, aux_reg, target_reg;

   always_comb begin
      stime_next = stage_reg[{plc_stage_index, 1'b0}];
      ramp_pick_w = stage_reg[{plc_stage_index, 1'b1}];
      accel_next = ramp_reg[{ramp_pick_w[1:0], 1'b0}];
      decel_next = ramp_reg[{ramp_pick_w[1:0], 1'b1}];
   end

   // ======================================================================
   // all state registered here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_sel_reg <= FREF_RST_WORD;
         aux_sel_reg <= FREF_RST_WORD;
         sup_sel_reg <= FREF_RST_WORD;
         step0_sel_reg <= FREF_RST_WORD;
         plc_cfg_reg <= FREF_RST_WORD;
         in_func_reg <= '{default: FREF_RST_WORD};
         step_val_reg <= '{default: FREF_RST_WORD};
         stage_reg <= '{default: FREF_RST_WORD};
         ramp_reg <= '{default: FREF_RST_WORD};
         rd_data_reg <= FREF_RST_WORD;
         wr_err_reg <= 1'b0;
         stime_reg <= FREF_RST_WORD;
         accel_reg <= FREF_RST_WORD;
         decel_reg <= FREF_RST_WORD;
         ms_reg <= '0;
         main_reg <= '0;
         aux_reg <= '0;
         target_reg <= '0;
      end else begin
         main_sel_reg <= main_sel_next;
         aux_sel_reg <= aux_sel_next;
         sup_sel_reg <= sup_sel_next;
         step0_sel_reg <= step0_sel_next;
         plc_cfg_reg <= plc_cfg_next;
         in_func_reg <= in_func_next;
         step_val_reg <= step_val_next;
         stage_reg <= stage_next;
         ramp_reg <= ramp_next;
         rd_data_reg <= rd_data_next;
         wr_err_reg <= wr_err_next;
         stime_reg <= stime_next;
         accel_reg <= accel_next;
         decel_reg <= decel_next;
         ms_reg <= ms_val;
         main_reg <= main_val;
         aux_reg <= aux_val;
         target_reg <= target_val;
      end
   end

   assign param_rd_data = rd_data_reg;
   assign param_wr_err = wr_err_reg;
   assign plc_stage_time = stime_reg;
   assign plc_accel_time = accel_reg;
   assign plc_decel_time = decel_reg;
   assign plc_cfg = fref_plc_cfg_t'(plc_cfg_reg);
   assign multistep_ref = ms_reg;
   assign main_ref = main_reg;
   assign aux_ref = aux_reg;
   assign target_freq = target_reg;

   // ======================================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic all_ms_func;
   assign all_ms_func = in_func_reg[0] == FREF_FUNC_MS1 && in_func_reg[1] == FREF_FUNC_MS2 &&
                        in_func_reg[2] == FREF_FUNC_MS3;

   a_main_multistep: assert property (
      main_sel_reg[3:0] == FREF_SRC_MULTI |=> main_ref == $past(ms_val))
      else $error("main ref not multi-step");
   a_main_plc: assert property (
      main_sel_reg[3:0] == FREF_SRC_PLC |=> main_ref == $past(src.plc))
      else $error("main ref not plc output");
   a_index_seven: assert property (
      all_ms_func && input_terminal_1 && input_terminal_2 && input_terminal_3 &&
      !param_wr_en |=> multistep_ref == step_val_reg[7])
      else $error("index 7 wrong step");
   a_index_zero: assert property (
      all_ms_func && !input_terminal_1 && !input_terminal_2 && !input_terminal_3
      |=> multistep_ref == $past(step0_val))
      else $error("index 0 not step-0 channel");
   a_aux_pot: assert property (
      aux_sel_reg[3:0] == FREF_SRC_POT |=> aux_ref == $past(src.pot))
      else $error("aux pot decode wrong");
   a_main_only: assert property (
      sup_sel_reg[3:0] == FREF_MODE_MAIN |=> target_freq == $past(main_val))
      else $error("main-only target wrong");
   a_comb_max: assert property (
      sup_sel_reg == 16'h0021 |=> $signed(target_freq) >= $signed($past(main_val)) &&
      $signed(target_freq) >= $signed($past(aux_val)))
      else $error("max result too small");
   a_switch_aux: assert property (
      sup_sel_reg[3:0] == FREF_MODE_SW_XY && sw_on |=> target_freq == $past(aux_val))
      else $error("switchover did not pick aux");
   a_sup_refuse: assert property (
      param_wr_en && param_addr == FREF_ADDR_SUP_SEL && param_wr_data > FREF_SUP_MAX
      |=> param_wr_err && $stable(sup_sel_reg))
      else $error("illegal superposition accepted");
   a_term_latency: assert property (
      $changed(ms_idx) && main_sel_reg[3:0] == FREF_SRC_MULTI && sup_sel_reg == 16'h0000
      |=> target_freq == $past(ms_val) && multistep_ref == $past(ms_val))
      else $error("terminal change not tracked");

   c_index_seven: cover property (all_ms_func && ms_idx == 3'h7);
   c_switch_on: cover property (sup_sel_reg[3:0] == FREF_MODE_SW_YC && sw_on);
   c_comb_min: cover property (sup_sel_reg == 16'h0031);
   c_wr_refused: cover property (param_wr_err);

endmodule

//--- inc/fref_pkg.sv
// constants, field layouts and carrier types for the frequency reference selector
// ======================================================================
// Functional notes
// - main source code 8 takes the multi-step reference as the main reference.
// - terminal function codes 21, 22 and 23 make a terminal multi-step input 1, 2 and 3.
// - the three multi-step inputs form a 3-bit index, input 1 the lsb, picking one of 8.
// - index 0 uses the channel chosen by the step-0 selector, indices 1 to 7 the stored steps.
// - the multi-step reference is also offered to the v/f voltage and pid setpoint users.
// - main source code 9 takes the simple plc sequencer output as the main reference.
// - each plc stage has its own running time and picks one of 4 shared accel/decel time pairs.
// - the plc configuration gives cycle mode, timing unit and retention on power loss or stop.
// - aux codes: 0 panel, 1 analog, 4 pot, 5 comm, 6 pulse, 7 pid, 8 multi-step, 9 plc; reset 0.
// - the aux reference alone is decoded exactly like the main reference.
// - main-only mode passes the main reference straight through as the target.
// - combination mode gives main+aux, main-aux, max or min as configured.
// - switchover mode picks main, aux or combined by a terminal holding function 28 to 30.
// - superposition low digit is the source mode, tens digit the operation, range 0x00 to 0x34.
package fref_pkg;

   // ======================================================================
   // widths
   localparam int FREF_W = 16;
   localparam int FREF_NUM_TERM = 3;
   localparam int FREF_NUM_STEP = 8;
   localparam int FREF_NUM_STAGE_WORD = 16;
   localparam int FREF_NUM_RAMP_WORD = 8;

   // ======================================================================
   // parameter addresses
   localparam logic [15:0] FREF_ADDR_MAIN_SEL = 16'h0104;
   localparam logic [15:0] FREF_ADDR_AUX_SEL = 16'h0105;
   localparam logic [15:0] FREF_ADDR_SUP_SEL = 16'h0108;
   localparam logic [15:0] FREF_ADDR_IN_FUNC0 = 16'h0800;
   localparam logic [15:0] FREF_ADDR_IN_FUNC2 = 16'h0802;
   localparam logic [15:0] FREF_ADDR_STEP0_SEL = 16'h1100;
   localparam logic [15:0] FREF_ADDR_STEP1 = 16'h1101;
   localparam logic [15:0] FREF_ADDR_STEP7 = 16'h1107;
   localparam logic [15:0] FREF_ADDR_PLC_CFG = 16'h1111;
   localparam logic [15:0] FREF_ADDR_STAGE_FIRST = 16'h1113;
   localparam logic [15:0] FREF_ADDR_STAGE_LAST = 16'h1122;
   localparam logic [15:0] FREF_ADDR_RAMP_FIRST = 16'h0117;
   localparam logic [15:0] FREF_ADDR_RAMP_LAST = 16'h011E;

   // ======================================================================
   // reset value and superposition code limit
   localparam logic [15:0] FREF_RST_WORD = 16'h0000;
   localparam logic [15:0] FREF_SUP_MAX = 16'h0034;

   // ======================================================================
   // source channel codes
   localparam logic [3:0] FREF_SRC_PANEL = 4'h0;
   localparam logic [3:0] FREF_SRC_ANALOG = 4'h1;
   localparam logic [3:0] FREF_SRC_POT = 4'h4;
   localparam logic [3:0] FREF_SRC_COMM = 4'h5;
   localparam logic [3:0] FREF_SRC_PULSE = 4'h6;
   localparam logic [3:0] FREF_SRC_PID = 4'h7;
   localparam logic [3:0] FREF_SRC_MULTI = 4'h8;
   localparam logic [3:0] FREF_SRC_PLC = 4'h9;

   // terminal function codes
   localparam logic [15:0] FREF_FUNC_MS1 = 16'h0015;
   localparam logic [15:0] FREF_FUNC_MS2 = 16'h0016;
   localparam logic [15:0] FREF_FUNC_MS3 = 16'h0017;
   localparam logic [15:0] FREF_FUNC_SW_LO = 16'h001C;
   localparam logic [15:0] FREF_FUNC_SW_HI = 16'h001E;

   // superposition digits
   localparam logic [3:0] FREF_MODE_MAIN = 4'h0;
   localparam logic [3:0] FREF_MODE_COMB = 4'h1;
   localparam logic [3:0] FREF_MODE_SW_XY = 4'h2;
   localparam logic [3:0] FREF_MODE_SW_XC = 4'h3;
   localparam logic [3:0] FREF_MODE_SW_YC = 4'h4;
   localparam logic [3:0] FREF_OP_SUM = 4'h0;
   localparam logic [3:0] FREF_OP_DIFF = 4'h1;
   localparam logic [3:0] FREF_OP_MAX = 4'h2;
   localparam logic [3:0] FREF_OP_MIN = 4'h3;

   // ======================================================================
   // carriers
   typedef struct packed {
      logic [FREF_W-1:0] panel;
      logic [FREF_W-1:0] analog;
      logic [FREF_W-1:0] pot;
      logic [FREF_W-1:0] comm;
      logic [FREF_W-1:0] pulse;
      logic [FREF_W-1:0] pid;
      logic [FREF_W-1:0] plc;
   } fref_src_t;

   // one hex digit per field, ones digit lowest
   typedef struct packed {
      logic [3:0] retain_stop;
      logic [3:0] retain_power;
      logic [3:0] time_unit;
      logic [3:0] cycle_mode;
   } fref_plc_cfg_t;

endpackage

//--- design/fref_src_mux.sv
// channel decoder shared by the main, auxiliary and step-0 selectors
`timescale 1ns/10ps
module fref_src_mux
   import fref_pkg::*;
(
   input wire logic [3:0] sel,
   input wire fref_src_t src,
   input wire logic [FREF_W-1:0] multi_ref,
   output logic [FREF_W-1:0] value
);

   // unused codes give zero so a bad setting parks the drive, not a stale value
   always_comb begin
      unique case (sel)
         FREF_SRC_PANEL: value = src.panel;
         FREF_SRC_ANALOG: value = src.analog;
         FREF_SRC_POT: value = src.pot;
         FREF_SRC_COMM: value = src.comm;
         FREF_SRC_PULSE: value = src.pulse;
         FREF_SRC_PID: value = src.pid;
         FREF_SRC_MULTI: value = multi_ref;
         FREF_SRC_PLC: value = src.plc;
         default: value = '0;
      endcase
   end

endmodule

//--- tb/fref_term_model.sv
// far-side model: terminal levels and fixed channel levels
`timescale 1ns/10ps
module fref_term_model
   import fref_pkg::*;
(
   input wire logic [2:0] level_idx,
   output logic input_terminal_1,
   output logic input_terminal_2,
   output logic input_terminal_3,
   output fref_src_t src
);
   // ======================================================================
   // terminals follow the commanded index, terminal 1 the low bit
   assign input_terminal_1 = level_idx[0];
   assign input_terminal_2 = level_idx[1];
   assign input_terminal_3 = level_idx[2];
   // distinct channel levels so a wrong decode never matches by chance
   assign src = '{panel: 16'h0064, analog: 16'h00C8, pot: 16'h012C, comm: 16'h0190,
                  pulse: 16'h01F4, pid: 16'h0258, plc: 16'h02BC};
endmodule

//--- tb/test_fref_selector.sv
// self-checking bench for the frequency reference selector
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module test_fref_selector
   import fref_pkg::*;
;
   typedef struct {logic [3:0] m; logic [3:0] a; logic [7:0] s; logic [2:0] i;
                   logic [15:0] ea; logic [15:0] et;} fref_row_t;
   logic core_clk, rst_n, t1, t2, t3, wr_en, wr_err;
   logic [15:0] addr, wdata, raddr, rdata, st_time, acc, dec, ms, mref, aref, tgt, d;
   logic [2:0] idx, stage;
   fref_src_t src;
   fref_plc_cfg_t cfg;
   int n_mismatch = 0, total_checks = 0, err_cnt = 0;
   // one superposition code per switch mode, with terminal on and off results
   logic [15:0] sw_mode [3] = '{16'h0002, 16'h0003, 16'h0034};
   logic [15:0] sw_hi [3] = '{16'h0190, 16'h02BC, 16'h012C};
   logic [15:0] sw_lo [3] = '{16'h012C, 16'h012C, 16'h0190};
   fref_row_t rows [11] = '{
      '{4'h8, 4'h0, 8'h00, 3'h5, 16'h0064, 16'h1005}, '{4'h8, 4'h0, 8'h00, 3'h0, 16'h0064, 16'h00C8},
      '{4'h9, 4'h1, 8'h00, 3'h0, 16'h00C8, 16'h02BC}, '{4'h4, 4'h5, 8'h01, 3'h0, 16'h0190, 16'h02BC},
      '{4'h4, 4'h5, 8'h11, 3'h0, 16'h0190, 16'hFF9C}, '{4'h4, 4'h5, 8'h21, 3'h0, 16'h0190, 16'h0190},
      '{4'h4, 4'h5, 8'h31, 3'h0, 16'h0190, 16'h012C}, '{4'h6, 4'h7, 8'h00, 3'h0, 16'h0258, 16'h01F4},
      '{4'h7, 4'h8, 8'h00, 3'h3, 16'h1003, 16'h0258}, '{4'h1, 4'h9, 8'h00, 3'h0, 16'h02BC, 16'h00C8},
      '{4'h0, 4'h4, 8'h00, 3'h0, 16'h012C, 16'h0064}};
   fref_term_model u_term (.level_idx(idx), .input_terminal_1(t1), .input_terminal_2(t2),
      .input_terminal_3(t3), .src(src));
   fref_selector u_dut (.core_clk(core_clk), .rst_n(rst_n), .input_terminal_1(t1),
      .input_terminal_2(t2), .input_terminal_3(t3), .src(src), .param_wr_en(wr_en),
      .param_addr(addr), .param_wr_data(wdata), .param_rd_addr(raddr),
      .param_rd_data(rdata), .param_wr_err(wr_err), .plc_stage_index(stage),
      .plc_stage_time(st_time), .plc_accel_time(acc), .plc_decel_time(dec), .plc_cfg(cfg),
      .multistep_ref(ms), .main_ref(mref), .aux_ref(aref), .target_freq(tgt));
   // ======================================================================
   // clock, 25 ns period
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // refused writes are counted here since the pulse lasts one cycle; sampled settled
   always @(negedge core_clk) begin
      if (wr_err === 1'b1) err_cnt++;
   end
   // ======================================================================
   // host write and read cycles, launched at the falling edge
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(negedge core_clk);
      wr_en = 1'b1;
      addr = a;
      wdata = v;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(negedge core_clk);
      raddr = a;
      @(negedge core_clk);
      d = rdata;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      $display("Error watchdog expired");
      final_report();
   end
   // ======================================================================
   // main sequence: reset, table of source cases, then awkward cases
   initial begin
      rst_n = 1'b0;
      {wr_en, addr, wdata, raddr, idx, stage} = '0;
      repeat (10) @(negedge core_clk);
      `CHK("tgt_in_reset", 16'h0000, tgt)
      rst_n = 1'b1;
      rd(FREF_ADDR_AUX_SEL);
      `CHK("aux_sel_reset", 16'h0000, d)
      `CHK("tgt_after_reset", 16'h0064, tgt)
      // terminal functions and stored steps; step 0 follows the analog channel
      for (int k = 0; k < 3; k++) wr(FREF_ADDR_IN_FUNC0 + 16'(k), FREF_FUNC_MS1 + 16'(k));
      for (int k = 1; k < 8; k++) wr(FREF_ADDR_STEP1 + 16'(k - 1), 16'h1000 + 16'(k));
      wr(FREF_ADDR_STEP0_SEL, 16'h0001);
      foreach (rows[r]) begin
         // aux first, so after the first row main and aux never share a channel between the two writes
         wr(FREF_ADDR_AUX_SEL, {12'h000, rows[r].a});
         wr(FREF_ADDR_MAIN_SEL, {12'h000, rows[r].m});
         wr(FREF_ADDR_SUP_SEL, {8'h00, rows[r].s});
         idx = rows[r].i;
         repeat (2) @(negedge core_clk);
         `CHK("aux_ref", rows[r].ea, aref)
         `CHK("target", rows[r].et, tgt)
      end
      // a terminal change shows exactly one edge later
      wr(FREF_ADDR_MAIN_SEL, 16'h0008);
      wr(FREF_ADDR_SUP_SEL, 16'h0000);
      @(negedge core_clk);
      idx = 3'h6;
      @(negedge core_clk);
      `CHK("ms_one_edge", 16'h1006, ms)
      `CHK("tgt_one_edge", 16'h1006, tgt)
      `CHK("main_ref", 16'h1006, mref)
      idx = 3'h7;
      @(negedge core_clk);
      `CHK("ms_step7", 16'h1007, ms)
      // switchover by terminal 3, one switch function code per switch mode
      wr(FREF_ADDR_AUX_SEL, 16'h0005);
      wr(FREF_ADDR_MAIN_SEL, 16'h0004);
      for (int k = 0; k < 3; k++) begin
         wr(FREF_ADDR_SUP_SEL, sw_mode[k]);
         wr(FREF_ADDR_IN_FUNC2, FREF_FUNC_SW_LO + 16'(k));
         idx = 3'h4;
         repeat (2) @(negedge core_clk);
         `CHK("switch_on", sw_hi[k], tgt)
         idx = 3'h0;
         repeat (2) @(negedge core_clk);
         `CHK("switch_off", sw_lo[k], tgt)
      end
      // refused writes: unmapped place, code above range, bad ones digit
      wr(FREF_ADDR_SUP_SEL, 16'h0021);
      for (int k = 0; k < 3; k++) begin
         err_cnt = 0;
         wr(k == 0 ? 16'h0200 : FREF_ADDR_SUP_SEL, k == 1 ? 16'h0035 : 16'h0005);
         rd(FREF_ADDR_SUP_SEL);
         `CHK("wr_err_count", 1, err_cnt)
         `CHK("sup_kept", 16'h0021, d)
      end
      // sequencer stage time, ramp pair and configuration
      wr(FREF_ADDR_PLC_CFG, 16'h1234);
      wr(FREF_ADDR_STAGE_FIRST + 16'h0002, 16'h0032);
      wr(FREF_ADDR_STAGE_FIRST + 16'h0003, 16'h0001);
      wr(FREF_ADDR_RAMP_FIRST + 16'h0002, 16'h0011);
      wr(FREF_ADDR_RAMP_FIRST + 16'h0003, 16'h0022);
      stage = 3'h1;
      repeat (2) @(negedge core_clk);
      `CHK("plc_cfg", 16'h1234, cfg)
      `CHK("stage_time", 16'h0032, st_time)
      `CHK("accel", 16'h0011, acc)
      `CHK("decel", 16'h0022, dec)
      final_report();
   end
endmodule
